//--- shared/wfram_pkg.sv
// Purpose: shared constants for the waveform ram sequencer
// Assumes: 32-bit words, two segment registers
// Notes: mode codes are the playback mode field values
package wfram_pkg;
  localparam int ADDR_W = 10;
  localparam int DEPTH = 1024;
  localparam int WORD_W = 32;
  localparam int SAMP_W = 16;
  localparam int BB_W = 18;
  localparam int RATE_W = 16;
  localparam int MODE_W = 3;
  localparam int NSEG = 2;
  localparam int I_MSB = 31;
  localparam int I_LSB = 16;
  localparam int Q_MSB = 15;
  localparam int Q_LSB = 0;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_MULT = 24'h000004;
  localparam logic [MODE_W-1:0] MODE_RAMP_UP = 3'h1;
  localparam logic [MODE_W-1:0] MODE_BIDIR = 3'h2;
  localparam logic [MODE_W-1:0] MODE_CONT_BIDIR = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RECIRC = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [RATE_W-1:0] RATE_RST = 16'h0001;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic [SAMP_W-1:0] SAMP_ZERO = 16'h0000;
endpackage

//--- hdl/wave_mem.sv
// Purpose: single port waveform memory, synchronous read
// Assumes: write and read share one address
// Notes: read data appears one clock after the address
`timescale 1ns/10ps
module wave_mem
  import wfram_pkg::*;
#(
  parameter int P_DEPTH = DEPTH,
  parameter int P_AW = ADDR_W,
  parameter int P_DW = WORD_W
)
(
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [P_AW-1:0] i_addr,
  input wire logic [P_DW-1:0] i_wdata,
  output logic [P_DW-1:0] o_rdata
);
  logic [P_DW-1:0] mem [P_DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    o_rdata <= mem[i_addr];
  end
endmodule

//--- hdl/waveform_ram_sequencer.sv
// Purpose: waveform ram, segment registers, address sequencer
// Assumes: i_clk is the system clock; i_bb_clk the baseband clock
// Notes: serial words arrive as strobes on i_clk
//
// Overview of operation
// [R1] ram usable only in upconvert or dac mode
// [R2] enable bit picks load/retrieve or playback
// [R3] destination bit routes to multipliers or chain
// [R4] parallel port off when chain is destination
// [R5] new settings act on update or profile
// [R6] upper half is i, lower half q
// [R7] chain sample msb aligned, sign fills lsbs
// [R8] multiplier sample is unsigned fraction
// [R9] two segments: start, end, rate, mode
// [R10] host keeps end above start
// [R11] host sets rate one for chain
// [R12] serial steps loads, baseband clock steps playback
// [R13] rise picks segment 0, fall segment 1
// [R14] host programs, toggles trigger, then transfers
// [R15] load address counts up per word
// [R16] overlap allowed, last write wins
// [R17] serial access beats playback
// [R18] multiplier sample every 4*r*m clocks
// [R19] update zeroes multipliers until trigger change
// [R20] chain steps address once per sample
// [R21] four playback modes per segment
// [R22] mode codes 1 to 4, others invalid
// [R23] continuous modes barred for multipliers
// [R24] ramp-up stops at end address
// [R25] trigger synchronised before edge detect
`timescale 1ns/10ps
module waveform_ram_sequencer
  import wfram_pkg::*;
#(
  parameter int R_W = 6
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bb_clk,
  input wire logic i_ram_mode_allowed,
  input wire logic i_io_update,
  input wire logic i_profile_change,
  input wire logic i_ram_enable,
  input wire logic i_dest_mult,
  input wire logic [ADDR_W-1:0] i_seg0_start,
  input wire logic [ADDR_W-1:0] i_seg0_end,
  input wire logic [RATE_W-1:0] i_seg0_rate,
  input wire logic [MODE_W-1:0] i_seg0_mode,
  input wire logic [ADDR_W-1:0] i_seg1_start,
  input wire logic [ADDR_W-1:0] i_seg1_end,
  input wire logic [RATE_W-1:0] i_seg1_rate,
  input wire logic [MODE_W-1:0] i_seg1_mode,
  input wire logic [R_W-1:0] i_interp_r,
  input wire logic i_playback_trigger_input,
  input wire logic i_ser_wr_valid,
  input wire logic [WORD_W-1:0] i_ser_wr_data,
  input wire logic i_ser_rd_req,
  output logic [WORD_W-1:0] o_ser_rd_data,
  output logic o_ser_rd_valid,
  output logic [BB_W-1:0] o_bb_i,
  output logic [BB_W-1:0] o_bb_q,
  output logic o_bb_valid,
  output logic [SAMP_W-1:0] o_i_scaling_multiplier,
  output logic [SAMP_W-1:0] o_q_scaling_multiplier,
  output logic o_par_port_disable,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_halted
);
  typedef enum logic [2:0] {
    st_idle, st_load, st_up, st_down, st_halt
  } seq_e;

  ////////////////////////////////////////////////////////////////////
  // active settings

  logic act_enable;
  logic act_dest_mult;
  logic [ADDR_W-1:0] act_start [NSEG];
  logic [ADDR_W-1:0] act_end [NSEG];
  logic [RATE_W-1:0] act_rate [NSEG];
  logic [MODE_W-1:0] act_mode [NSEG];
  logic [ADDR_W-1:0] pend_start [NSEG];
  logic [ADDR_W-1:0] pend_end [NSEG];
  logic [RATE_W-1:0] pend_rate [NSEG];
  logic [MODE_W-1:0] pend_mode [NSEG];
  logic apply;

  assign apply = i_io_update | i_profile_change;
  assign pend_start[0] = i_seg0_start;
  assign pend_start[1] = i_seg1_start;
  assign pend_end[0] = i_seg0_end;
  assign pend_end[1] = i_seg1_end;
  assign pend_rate[0] = i_seg0_rate;
  assign pend_rate[1] = i_seg1_rate;
  assign pend_mode[0] = i_seg0_mode;
  assign pend_mode[1] = i_seg1_mode;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      act_enable <= 1'b0;
      act_dest_mult <= 1'b0;
    end
    else if (apply)
    begin
      act_enable <= i_ram_enable; // R2 R5
      act_dest_mult <= i_dest_mult; // R3 R5
    end
  end

  for (genvar s = 0; s < NSEG; s++)
  begin : g_seg
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        act_start[s] <= ADDR_RST;
        act_end[s] <= ADDR_RST;
        act_rate[s] <= RATE_RST;
        act_mode[s] <= MODE_RST;
      end
      else if (apply)
      begin
        act_start[s] <= pend_start[s]; // R9 R5
        act_end[s] <= pend_end[s];
        act_rate[s] <= pend_rate[s];
        act_mode[s] <= pend_mode[s];
      end
    end
  end

  logic play_on;
  assign play_on = act_enable & i_ram_mode_allowed; // R1
  assign o_par_port_disable = play_on & ~act_dest_mult; // R4

  ////////////////////////////////////////////////////////////////////
  // trigger and baseband tick crossings

  logic trig_s1;
  logic trig_s2;
  logic trig_d;
  logic trig_rise;
  logic trig_fall;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_d <= 1'b0;
    end
    else
    begin
      trig_s1 <= i_playback_trigger_input; // R25
      trig_s2 <= trig_s1;
      trig_d <= trig_s2;
    end
  end

  assign trig_rise = trig_s2 & ~trig_d; // R13
  assign trig_fall = ~trig_s2 & trig_d; // R13

  logic bb_tog;
  logic bb_s1;
  logic bb_s2;
  logic bb_d;
  logic bb_tick;

  logic rst_bb_s1;
  logic rst_bb_s2;

  // reset reaches the link domain through two flops
  always_ff @(posedge i_bb_clk)
  begin
    rst_bb_s1 <= i_rst;
    rst_bb_s2 <= rst_bb_s1;
  end

  // toggles once per baseband sample on the link clock
  always_ff @(posedge i_bb_clk)
  begin
    if (rst_bb_s2)
    begin
      bb_tog <= 1'b0;
    end
    else
    begin
      bb_tog <= ~bb_tog;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bb_s1 <= 1'b0;
      bb_s2 <= 1'b0;
      bb_d <= 1'b0;
    end
    else
    begin
      bb_s1 <= bb_tog;
      bb_s2 <= bb_s1;
      bb_d <= bb_s2;
    end
  end

  assign bb_tick = bb_s2 ^ bb_d; // R12 R20

  ////////////////////////////////////////////////////////////////////
  // sample timer for the multiplier destination

  logic sel;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] period;
  logic tmr_tick;
  logic step;
  logic trig_any;

  assign trig_any = trig_rise | trig_fall;
  assign period = TMR_W'(TMR_MULT * TMR_W'(i_interp_r)
    * TMR_W'(act_rate[sel])); // R18
  assign tmr_tick = (tmr >= period - TMR_W'(1));

  always_ff @(posedge i_clk)
  begin
    if (i_rst || trig_any || apply || tmr_tick)
    begin
      tmr <= '0;
    end
    else
    begin
      tmr <= tmr + TMR_W'(1);
    end
  end

  assign step = act_dest_mult ? tmr_tick : bb_tick; // R18 R20

  ////////////////////////////////////////////////////////////////////
  // address sequencer

  seq_e state;
  logic [ADDR_W-1:0] addr;
  logic [MODE_W-1:0] cur_mode;
  logic [ADDR_W-1:0] cur_start;
  logic [ADDR_W-1:0] cur_end;
  logic mode_ok;
  logic ser_acc;
  logic next_sel;

  assign next_sel = trig_fall; // R13
  assign cur_mode = act_mode[sel];
  assign cur_start = act_start[sel];
  assign cur_end = act_end[sel];
  assign ser_acc = i_ser_wr_valid | i_ser_rd_req; // R12

  // invalid codes and barred continuous modes halt at the start address
  always_comb
  begin
    case (act_mode[next_sel])
      MODE_RAMP_UP, MODE_BIDIR: mode_ok = 1'b1; // R21 R22
      MODE_CONT_BIDIR, MODE_RECIRC: mode_ok = ~act_dest_mult; // R23
      default: mode_ok = 1'b0; // R22
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sel <= 1'b0;
    end
    else if (trig_any)
    begin
      sel <= next_sel; // R13
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_ram_mode_allowed)
    begin
      state <= st_idle; // R1
      addr <= ADDR_RST;
    end
    else if (trig_any)
    begin
      if (!act_enable)
      begin
        state <= st_load; // R14
        addr <= act_start[next_sel];
      end
      else if (!mode_ok)
      begin
        state <= st_halt;
        addr <= act_start[next_sel];
      end
      else if (act_mode[next_sel] == MODE_BIDIR && next_sel)
      begin
        state <= st_down;
        addr <= act_end[next_sel];
      end
      else
      begin
        state <= st_up;
        addr <= act_start[next_sel];
      end
    end
    else if (ser_acc)
    begin
      addr <= addr + ADDR_ONE; // R15 R17
    end
    else if (step)
    begin
      case (state)
        st_up:
        begin
          if (addr != cur_end)
          begin
            addr <= addr + ADDR_ONE; // R20
          end
          else if (cur_mode == MODE_CONT_BIDIR)
          begin
            state <= st_down; // R21
            addr <= addr - ADDR_ONE;
          end
          else if (cur_mode == MODE_RECIRC)
          begin
            addr <= cur_start; // R21
          end
          else
          begin
            state <= st_halt; // R24
          end
        end
        st_down:
        begin
          if (addr != cur_start)
          begin
            addr <= addr - ADDR_ONE; // R20
          end
          else if (cur_mode == MODE_CONT_BIDIR)
          begin
            state <= st_up;
            addr <= addr + ADDR_ONE;
          end
          else
          begin
            state <= st_halt;
          end
        end
        default:
        begin
          state <= state;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // memory and outputs

  logic [WORD_W-1:0] rdata;
  logic we;
  logic rd_d;
  logic play_d;
  logic mult_zero;

  assign we = i_ser_wr_valid & i_ram_mode_allowed; // R1 R16 R17

  wave_mem #(
    .P_DEPTH(DEPTH),
    .P_AW(ADDR_W),
    .P_DW(WORD_W)
  ) u_mem (
    .i_clk(i_clk),
    .i_we(we),
    .i_addr(addr),
    .i_wdata(i_ser_wr_data),
    .o_rdata(rdata)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      mult_zero <= 1'b1;
    end
    else if (trig_any)
    begin
      mult_zero <= 1'b0; // R19
    end
    else if (apply && i_ram_enable && i_dest_mult)
    begin
      mult_zero <= 1'b1; // R19
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_d <= 1'b0;
      play_d <= 1'b0;
      o_ser_rd_valid <= 1'b0;
      o_ser_rd_data <= '0;
    end
    else
    begin
      rd_d <= i_ser_rd_req & i_ram_mode_allowed; // R1
      play_d <= play_on && !ser_acc && (state == st_up
        || state == st_down || state == st_halt);
      o_ser_rd_valid <= rd_d;
      if (rd_d)
      begin
        o_ser_rd_data <= rdata;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_bb_i <= '0;
      o_bb_q <= '0;
      o_bb_valid <= 1'b0;
    end
    else
    begin
      o_bb_valid <= play_d && !act_dest_mult;
      if (play_d && !act_dest_mult)
      begin
        o_bb_i <= {rdata[I_MSB:I_LSB], {2{rdata[I_MSB]}}}; // R6 R7
        o_bb_q <= {rdata[Q_MSB:Q_LSB], {2{rdata[Q_MSB]}}}; // R7
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || mult_zero)
    begin
      o_i_scaling_multiplier <= SAMP_ZERO; // R19
      o_q_scaling_multiplier <= SAMP_ZERO;
    end
    else if (play_d && act_dest_mult)
    begin
      o_i_scaling_multiplier <= rdata[I_MSB:I_LSB]; // R8
      o_q_scaling_multiplier <= rdata[Q_MSB:Q_LSB]; // R8
    end
  end

  assign o_addr = addr;
  assign o_halted = (state == st_halt);

  ////////////////////////////////////////////////////////////////////
  // checks

  sequence s_rise;
    trig_rise;
  endsequence

  sequence s_fall;
    trig_fall;
  endsequence

  a_rise_seg0: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    s_rise |=> !sel) else $error("rise not seg0");
  a_fall_seg1: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    s_fall |=> sel) else $error("fall not seg1");
  a_trig_sync: assert property (@(posedge i_clk) disable iff (i_rst) // R25
    trig_rise |-> $past(i_playback_trigger_input, 2))
    else $error("edge not synced");
  a_load_up: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    i_ser_wr_valid && !trig_any && i_ram_mode_allowed
    |=> addr == $past(addr) + ADDR_ONE)
    else $error("load not upward");
  a_port_off: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    apply && i_ram_enable && !i_dest_mult
    |=> o_par_port_disable || !i_ram_mode_allowed)
    else $error("port not disabled");
  a_upd_zero: assert property (@(posedge i_clk) disable iff (i_rst) // R19
    apply && i_ram_enable && i_dest_mult && !trig_any
    |=> ##1 o_i_scaling_multiplier == SAMP_ZERO
    && o_q_scaling_multiplier == SAMP_ZERO)
    else $error("multiplier not zero");
  a_bb_sign: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    o_bb_valid |-> o_bb_i[1:0] == {2{o_bb_i[BB_W-1]}})
    else $error("sign fill wrong");
  a_ramp_halt: assert property (@(posedge i_clk) disable iff (i_rst) // R24
    state == st_up && cur_mode == MODE_RAMP_UP && addr == cur_end
    && step && !ser_acc && !trig_any && i_ram_mode_allowed
    |=> state == st_halt) else $error("ramp not halted");
  a_cont_barred: assert property (@(posedge i_clk) disable iff (i_rst) // R23
    trig_any && act_enable && act_dest_mult
    && act_mode[next_sel] == MODE_RECIRC && i_ram_mode_allowed
    |=> state == st_halt) else $error("recirc allowed");
  a_hold_cfg: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    !apply |=> act_enable == $past(act_enable))
    else $error("enable changed early");
endmodule

//--- testbench/host_model.sv
// Purpose: host side model driving trigger pin and serial words
// Assumes: one serial word per strobe, strobes one clock wide
// Notes: released data lines show the inverse of the last word
`timescale 1ns/10ps
module host_model
  import wfram_pkg::*;
(
  input wire logic i_clk,
  output logic o_trig,
  output logic o_wr_valid,
  output logic [WORD_W-1:0] o_wr_data,
  output logic o_rd_req
);
  initial
  begin
    o_trig = 1'b0;
    o_wr_valid = 1'b0;
    o_wr_data = '0;
    o_rd_req = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger level change picks the segment before any transfer
  task automatic set_trig(input logic lvl);
    @(posedge i_clk);
    o_trig <= lvl;
  endtask

  task automatic send_word(input logic [WORD_W-1:0] w);
    @(posedge i_clk);
    o_wr_valid <= 1'b1;
    o_wr_data <= w;
    @(posedge i_clk);
    o_wr_valid <= 1'b0;
    o_wr_data <= ~w;
  endtask

  task automatic read_word();
    @(posedge i_clk);
    o_rd_req <= 1'b1;
    @(posedge i_clk);
    o_rd_req <= 1'b0;
  endtask
endmodule

//--- testbench/testbench.sv
// Purpose: self-checking bench for the waveform ram sequencer
// Assumes: host model drives trigger and serial port
// Notes: playback mode cases run from a table
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("BAD t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module testbench;
  import wfram_pkg::*;
  typedef struct packed
  {
    logic [MODE_W-1:0] mode;
    logic mult;
    logic halt;
  } row_s;
  localparam int R_SET = 2;
  localparam int M_SET = 2;
  logic clk, rst, bb_clk, allowed, io_update, profile_change;
  logic ram_enable, dest_mult, trig_pin, wr_valid, rd_req, lvl;
  logic [ADDR_W-1:0] seg_start [2];
  logic [ADDR_W-1:0] seg_end [2];
  logic [RATE_W-1:0] seg_rate [2];
  logic [MODE_W-1:0] seg_mode [2];
  logic [5:0] interp_r;
  logic [WORD_W-1:0] wr_data, rd_data;
  logic rd_valid, bb_valid, par_dis, halted;
  logic [BB_W-1:0] bb_i, bb_q;
  logic [SAMP_W-1:0] mult_i, mult_q;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wd [8] = '{32'h1111aaaa, 32'h2222bbbb, 32'h3333cccc,
    32'h7fff8000, 32'h4444dddd, 32'h5555eeee, 32'h66660001, 32'h80017ffe};
  row_s rows [11] = '{'{3'h0, 1'b0, 1'b1}, '{3'h1, 1'b1, 1'b0},
    '{3'h2, 1'b1, 1'b0}, '{3'h2, 1'b1, 1'b0}, '{3'h3, 1'b0, 1'b0},
    '{3'h4, 1'b0, 1'b0}, '{3'h5, 1'b0, 1'b1}, '{3'h6, 1'b1, 1'b1},
    '{3'h7, 1'b0, 1'b1}, '{3'h3, 1'b1, 1'b1}, '{3'h4, 1'b1, 1'b1}};
  int fails = 0;
  int n_tests = 0;
  int k;
  logic [ADDR_W-1:0] exp_addr;

  waveform_ram_sequencer #(.R_W(6)) dut (.i_clk(clk), .i_rst(rst),
    .i_bb_clk(bb_clk), .i_ram_mode_allowed(allowed),
    .i_io_update(io_update), .i_profile_change(profile_change),
    .i_ram_enable(ram_enable), .i_dest_mult(dest_mult),
    .i_seg0_start(seg_start[0]), .i_seg0_end(seg_end[0]),
    .i_seg0_rate(seg_rate[0]), .i_seg0_mode(seg_mode[0]),
    .i_seg1_start(seg_start[1]), .i_seg1_end(seg_end[1]),
    .i_seg1_rate(seg_rate[1]), .i_seg1_mode(seg_mode[1]),
    .i_interp_r(interp_r), .i_playback_trigger_input(trig_pin),
    .i_ser_wr_valid(wr_valid), .i_ser_wr_data(wr_data),
    .i_ser_rd_req(rd_req), .o_ser_rd_data(rd_data),
    .o_ser_rd_valid(rd_valid), .o_bb_i(bb_i), .o_bb_q(bb_q),
    .o_bb_valid(bb_valid), .o_i_scaling_multiplier(mult_i),
    .o_q_scaling_multiplier(mult_q), .o_par_port_disable(par_dis),
    .o_addr(addr), .o_halted(halted));
  host_model hm (.i_clk(clk), .o_trig(trig_pin), .o_wr_valid(wr_valid),
    .o_wr_data(wr_data), .o_rd_req(rd_req));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    bb_clk = 1'b0;
    #1.3;
    forever #3 bb_clk = ~bb_clk;
  end
  initial
  begin
    #100000;
    fails++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic set_seg(input logic s, input logic [ADDR_W-1:0] st,
    input logic [ADDR_W-1:0] en, input logic [RATE_W-1:0] rt,
    input logic [MODE_W-1:0] md);
    @(posedge clk);
    seg_start[s] <= st;
    seg_end[s] <= en;
    seg_rate[s] <= rt;
    seg_mode[s] <= md;
  endtask

  task automatic apply(input logic prof, input logic en, input logic mul);
    @(posedge clk);
    io_update <= ~prof;
    profile_change <= prof;
    ram_enable <= en;
    dest_mult <= mul;
    @(posedge clk);
    io_update <= 1'b0;
    profile_change <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic trig(input logic l);
    hm.set_trig(l);
    repeat (5) @(negedge clk);
  endtask

  task automatic wait_halt();
    k = 0;
    while (halted !== 1'b1 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
    // data outputs trail the address by two clocks
    repeat (2) @(negedge clk);
  endtask

  // waits for addr to reach a, then counts clocks until it leaves
  task automatic wait_leave(input logic [ADDR_W-1:0] a);
    k = 0;
    while (addr !== a && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (addr === a && k < 100)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    allowed = 1'b1;
    io_update = 1'b0;
    profile_change = 1'b0;
    ram_enable = 1'b0;
    dest_mult = 1'b0;
    interp_r = 6'(R_SET);
    seg_start = '{10'h000, 10'h000};
    seg_end = '{10'h000, 10'h000};
    seg_rate = '{RATE_RST, RATE_RST};
    seg_mode = '{MODE_RST, MODE_RST};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(addr, ADDR_RST)
    `CHK(mult_i, SAMP_ZERO)
    `CHK(par_dis, 1'b0)
    // overlapping segments, seg1 written last
    set_seg(1'b0, 10'h004, 10'h007, RATE_RST, MODE_RAMP_UP);
    set_seg(1'b1, 10'h006, 10'h009, RATE_RST, MODE_RAMP_UP);
    apply(1'b0, 1'b0, 1'b0);
    for (int s = 0; s < 2; s++)
    begin
      trig(s == 0);
      `CHK(addr, s ? 10'h006 : 10'h004)
      for (int i = 0; i < 4; i++)
        hm.send_word(wd[s * 4 + i]);
      @(negedge clk);
      `CHK(addr, s ? 10'h00a : 10'h008)
    end
    trig(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      hm.read_word();
      k = 0;
      while (rd_valid !== 1'b1 && k < 5)
      begin
        @(negedge clk);
        k++;
      end
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, (i < 2) ? wd[i] : wd[i + 2])
    end
    // playback into the baseband chain
    `CHK(par_dis, 1'b0)
    apply(1'b0, 1'b1, 1'b0);
    `CHK(par_dis, 1'b1)
    trig(1'b0);
    wait_halt();
    `CHK(addr, 10'h009)
    `CHK(bb_i, {wd[7][31:16], {2{wd[7][31]}}})
    `CHK(bb_q, {wd[7][15:0], {2{wd[7][15]}}})
    `CHK(bb_valid, 1'b1)
    // playback into the scaling multipliers
    set_seg(1'b0, 10'h004, 10'h007, 16'(M_SET), MODE_RAMP_UP);
    apply(1'b1, 1'b1, 1'b1);
    `CHK(mult_i, SAMP_ZERO)
    `CHK(par_dis, 1'b0)
    trig(1'b1);
    `CHK(addr, 10'h004)
    wait_leave(10'h005);
    `CHK(k, 4 * R_SET * M_SET)
    wait_halt();
    `CHK(addr, 10'h007)
    `CHK(mult_i, wd[5][31:16])
    `CHK(mult_q, wd[5][15:0])
    apply(1'b0, 1'b1, 1'b1);
    `CHK(mult_i, SAMP_ZERO)
    lvl = 1'b1;
    foreach (rows[r])
    begin
      for (int s = 0; s < 2; s++)
        set_seg(s[0], 10'h004, 10'h007, rows[r].mult ? 16'h0100 : RATE_RST,
          rows[r].mode);
      apply(1'b0, 1'b1, rows[r].mult);
      lvl = ~lvl;
      trig(lvl);
      repeat (3) @(negedge clk);
      `CHK(halted, rows[r].halt)
      exp_addr = (rows[r].mode == MODE_BIDIR && !lvl) ? 10'h007 : 10'h004;
      if (rows[r].mult | rows[r].halt)
        `CHK(addr, exp_addr)
    end
    // continuous modes turn round or wrap at the end address
    for (int m = MODE_CONT_BIDIR; m <= MODE_RECIRC; m++)
    begin
      for (int s = 0; s < 2; s++)
        set_seg(s[0], 10'h004, 10'h007, RATE_RST, MODE_W'(m));
      apply(1'b0, 1'b1, 1'b0);
      lvl = ~lvl;
      trig(lvl);
      wait_leave(10'h007);
      exp_addr = (MODE_W'(m) == MODE_CONT_BIDIR) ? 10'h006 : 10'h004;
      `CHK(addr, exp_addr)
    end
    @(posedge clk);
    allowed <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(addr, ADDR_RST)
    `CHK(par_dis, 1'b0)
    @(posedge clk);
    allowed <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(addr, ADDR_RST)
    `CHK(halted, 1'b0)
    finish_test();
  end
endmodule
